/* File: design/ubi_uart_ctl.sv */
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - With the receive interrupt enable set, overrun or receive-data-available raises the request; clear, they have no effect.
// - With the UART enabled and the idle interrupt enable set, the transmitter idle flag raises the request; clear, it has no effect.
// - With the UART enabled and the empty interrupt enable set, the transmit-empty flag raises the request; clear, it has no effect.
// - One 8-bit data register: writes supply the byte to send, reads return the byte received.
// - The baud rate comes from a dedicated free-running 8-bit timer set by divisor and speed select.
// - Baud rate is clock over 64(N+1) with low speed and over 16(N+1) with high speed.
// - Every divisor value from 0 to 255 is usable.
// - Disabling the UART clears receive, overrun and error flags, sets idle and empty, clears the transmit and receive enables, and keeps divisor and other control.
module ubi_uart_ctl (
   input wire logic core_clk, // System clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic [2:0] addr, // Register word address
   input wire logic [7:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [7:0] rdata, // Read data, cycle after rd
   output logic uart_irq, // UART interrupt request, level
   output logic sys_irq, // Masked sticky-event interrupt, level
   output logic baud_tick, // One pulse per bit time
   output logic [7:0] tx_byte, // Byte handed to the transmit shifter
   output logic tx_load, // Pulse: tx_byte valid
   input wire logic tx_taken, // Pulse: shifter took the buffered byte
   input wire logic tx_done, // Pulse: last stop bit sent, shifter empty
   input wire logic [7:0] rx_byte, // Byte from the receive shifter
   input wire logic rx_valid, // Pulse: rx_byte complete
   input wire logic rx_frame_err, // Pulse: framing error on rx_byte
   input wire logic rx_parity_err, // Pulse: parity error on rx_byte
   input wire logic rx_noise, // Pulse: noise seen on rx_byte
   output logic tx_enable, // Transmitter active
   output logic rx_enable // Receiver active
);
   logic [7:0] ctrl2_r;
   logic [7:0] ctrl1_r;
   logic [7:0] div_r;
   logic [7:0] rxbuf_r;
   logic [7:0] txbuf_r;
   logic tx_load_r;
   ubi_pkg::ubi_flags_t flg_r;
   logic ferr_r;
   logic perr_r;
   logic nf_r;
   logic stat_seen_r;
   logic [7:0] rdata_r;
   logic [2:0] ev_stat;
   logic [2:0] ev_mask;

   ubi_pkg::ubi_bus_t bus;
   assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   wire logic uart_en = ctrl1_r[ubi_pkg::CTL1_UART_EN];
   wire logic wr_ctrl2 = bus.wr && bus.addr == ubi_pkg::ADDR_CTRL2;
   wire logic wr_ctrl1 = bus.wr && bus.addr == ubi_pkg::ADDR_CTRL1;
   wire logic wr_div = bus.wr && bus.addr == ubi_pkg::ADDR_DIV;
   wire logic wr_data = bus.wr && bus.addr == ubi_pkg::ADDR_DATA;
   wire logic rd_data = bus.rd && bus.addr == ubi_pkg::ADDR_DATA;
   wire logic rd_stat = bus.rd && bus.addr == ubi_pkg::ADDR_STATUS;
   wire logic wr_iclr = bus.wr && bus.addr == ubi_pkg::ADDR_IRQ_STAT;
   wire logic wr_imask = bus.wr && bus.addr == ubi_pkg::ADDR_IRQ_MASK;
   // A data write lands only when the buffer is empty and the status was read
   wire logic tx_accept = wr_data && flg_r.tx_empty && stat_seen_r && uart_en;
   wire logic disabling = wr_ctrl1 && !bus.wdata[ubi_pkg::CTL1_UART_EN] && uart_en;
   wire logic off = !uart_en || disabling;

   wire logic [7:0] stat_word = {2'b00, flg_r.overrun, ferr_r, perr_r | nf_r, flg_r.rx_avail,
                                 flg_r.tx_idle, flg_r.tx_empty};

   // Control and divisor registers
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         ctrl2_r <= ubi_pkg::CTRL2_RST;
         ctrl1_r <= ubi_pkg::CTRL1_RST;
         div_r <= ubi_pkg::DIV_RST;
      end
      else
      begin
         if (wr_ctrl1)
            ctrl1_r <= bus.wdata;
         if (wr_ctrl2)
            ctrl2_r <= bus.wdata;
         else if (disabling)
            ctrl2_r <= ctrl2_r & 8'h3F;
         if (wr_div)
            div_r <= bus.wdata;
      end
   end

   // Transmit buffer and handoff to the shifter
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         txbuf_r <= 8'h00;
         tx_load_r <= 1'b0;
      end
      else
      begin
         if (tx_accept)
            txbuf_r <= bus.wdata;
         tx_load_r <= tx_accept;
      end
   end
   assign tx_byte = txbuf_r;
   assign tx_load = tx_load_r;

   // Receive buffer
   always_ff @(posedge core_clk)
   begin
      if (rst)
         rxbuf_r <= 8'h00;
      else if (rx_valid && uart_en)
         rxbuf_r <= rx_byte;
   end

   // Status flags; a setting event wins over a clearing access
   always_ff @(posedge core_clk)
   begin
      if (rst || off)
      begin
         flg_r.overrun <= 1'b0;
         flg_r.rx_avail <= 1'b0;
         flg_r.tx_idle <= 1'b1;
         flg_r.tx_empty <= 1'b1;
         ferr_r <= 1'b0;
         perr_r <= 1'b0;
         nf_r <= 1'b0;
         stat_seen_r <= 1'b0;
      end
      else
      begin
         flg_r.rx_avail <= rx_valid || (flg_r.rx_avail && !rd_data);
         flg_r.overrun <= (rx_valid && flg_r.rx_avail && !rd_data)
                          || (flg_r.overrun && !(stat_seen_r && rd_data));
         ferr_r <= rx_frame_err || (ferr_r && !(stat_seen_r && rd_data));
         perr_r <= rx_parity_err || (perr_r && !(stat_seen_r && rd_data));
         nf_r <= rx_noise || (nf_r && !(stat_seen_r && rd_data));
         flg_r.tx_empty <= tx_taken || (flg_r.tx_empty && !tx_accept);
         flg_r.tx_idle <= tx_done || (flg_r.tx_idle && !tx_accept);
         if (rd_stat)
            stat_seen_r <= 1'b1;
         else if (tx_accept || rd_data)
            stat_seen_r <= 1'b0;
      end
   end

   // Read mux, registered one cycle
   wire logic [7:0] rd_mux =
      (bus.addr == ubi_pkg::ADDR_CTRL2) ? ctrl2_r :
      (bus.addr == ubi_pkg::ADDR_DATA) ? rxbuf_r :
      (bus.addr == ubi_pkg::ADDR_DIV) ? div_r :
      (bus.addr == ubi_pkg::ADDR_STATUS) ? stat_word :
      (bus.addr == ubi_pkg::ADDR_CTRL1) ? ctrl1_r :
      (bus.addr == ubi_pkg::ADDR_IRQ_STAT) ? {5'h00, ev_stat} :
      (bus.addr == ubi_pkg::ADDR_IRQ_MASK) ? {5'h00, ev_mask} : 8'h00;
   always_ff @(posedge core_clk)
   begin
      if (rst)
         rdata_r <= 8'h00;
      else
         rdata_r <= bus.rd ? rd_mux : 8'h00;
   end
   assign rdata = rdata_r;

   // Interrupt request: UART enable AND the OR of every enabled source
   wire logic src_rx = ctrl2_r[ubi_pkg::CTL_RX_IE] && (flg_r.overrun || flg_r.rx_avail);
   wire logic src_idle = ctrl2_r[ubi_pkg::CTL_TXI_IE] && flg_r.tx_idle;
   wire logic src_empty = ctrl2_r[ubi_pkg::CTL_TXE_IE] && flg_r.tx_empty;
   assign uart_irq = uart_en && (src_rx || src_idle || src_empty);

   assign tx_enable = uart_en && ctrl2_r[ubi_pkg::CTL_TX_EN];
   assign rx_enable = uart_en && ctrl2_r[ubi_pkg::CTL_RX_EN];

   // Rising edges of the flags feed the sticky event register
   logic rx_q_r;
   logic idle_q_r;
   logic empty_q_r;
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         rx_q_r <= 1'b0;
         idle_q_r <= 1'b1;
         empty_q_r <= 1'b1;
      end
      else
      begin
         rx_q_r <= flg_r.rx_avail || flg_r.overrun;
         idle_q_r <= flg_r.tx_idle;
         empty_q_r <= flg_r.tx_empty;
      end
   end
   wire logic [2:0] ev;
   assign ev[ubi_pkg::EV_RX] = (flg_r.rx_avail || flg_r.overrun) && !rx_q_r;
   assign ev[ubi_pkg::EV_TX_IDLE] = flg_r.tx_idle && !idle_q_r;
   assign ev[ubi_pkg::EV_TX_EMPTY] = flg_r.tx_empty && !empty_q_r;

   ubi_irq #(.W(ubi_pkg::EV_WIDTH)) u_irq (
      .core_clk(core_clk),
      .rst(rst),
      .ev(ev),
      .clr_we(wr_iclr),
      .mask_we(wr_imask),
      .wdata(bus.wdata[2:0]),
      .stat_r(ev_stat),
      .mask_r(ev_mask),
      .irq(sys_irq)
   );

   ubi_baud_gen u_baud (
      .core_clk(core_clk),
      .rst(rst),
      .run(uart_en),
      .high_speed(ctrl2_r[ubi_pkg::CTL_HS_SEL]),
      .divisor(div_r),
      .tick(baud_tick)
   );

   property p_rx_irq;
      @(posedge core_clk) disable iff (rst)
      (uart_en && ctrl2_r[ubi_pkg::CTL_RX_IE] && (flg_r.rx_avail || flg_r.overrun)) |-> uart_irq;
   endproperty
   a_rx_irq: assert property (p_rx_irq) else $error("rx irq missing");

   property p_rx_quiet;
      @(posedge core_clk) disable iff (rst)
      (!ctrl2_r[2] && !ctrl2_r[1] && !ctrl2_r[0]) |-> !uart_irq;
   endproperty
   a_rx_quiet: assert property (p_rx_quiet) else $error("irq without enable");

   property p_idle_irq;
      @(posedge core_clk) disable iff (rst)
      (uart_en && ctrl2_r[1] && flg_r.tx_idle) |-> uart_irq;
   endproperty
   a_idle_irq: assert property (p_idle_irq) else $error("idle irq missing");

   property p_empty_irq;
      @(posedge core_clk) disable iff (rst)
      (uart_en && ctrl2_r[0] && flg_r.tx_empty) |-> uart_irq;
   endproperty
   a_empty_irq: assert property (p_empty_irq) else $error("empty irq missing");

   property p_rx_read;
      @(posedge core_clk) disable iff (rst)
      rd_data |=> (rdata == $past(rxbuf_r));
   endproperty
   a_rx_read: assert property (p_rx_read) else $error("data read wrong");

   property p_tx_block;
      @(posedge core_clk) disable iff (rst)
      (wr_data && !flg_r.tx_empty) |=> (!tx_load && $stable(txbuf_r));
   endproperty
   a_tx_block: assert property (p_tx_block) else $error("write not blocked");

   property p_disable;
      @(posedge core_clk) disable iff (rst)
      disabling |=> (flg_r.tx_empty && flg_r.tx_idle && !flg_r.rx_avail && !flg_r.overrun
                     && $stable(div_r));
   endproperty
   a_disable: assert property (p_disable) else $error("disable state wrong");

   property p_div_keep;
      @(posedge core_clk) disable iff (rst)
      (wr_div) |=> (div_r == $past(bus.wdata)) ##1 (div_r == $past(div_r) || $past(wr_div));
   endproperty
   a_div_keep: assert property (p_div_keep) else $error("divisor not kept");

   property p_rx_no_effect;
      @(posedge core_clk) disable iff (rst)
      (!ctrl2_r[ubi_pkg::CTL_RX_IE] && !(ctrl2_r[ubi_pkg::CTL_TXI_IE] && flg_r.tx_idle)
       && !(ctrl2_r[ubi_pkg::CTL_TXE_IE] && flg_r.tx_empty)) |-> !uart_irq;
   endproperty
   a_rx_no_effect: assert property (p_rx_no_effect) else $error("rx flags reach irq");

   property p_idle_no_effect;
      @(posedge core_clk) disable iff (rst)
      (!ctrl2_r[ubi_pkg::CTL_TXI_IE] && !(ctrl2_r[ubi_pkg::CTL_RX_IE] && flg_r.rx_avail)
       && !(ctrl2_r[ubi_pkg::CTL_RX_IE] && flg_r.overrun)
       && !(ctrl2_r[ubi_pkg::CTL_TXE_IE] && flg_r.tx_empty)) |-> !uart_irq;
   endproperty
   a_idle_no_effect: assert property (p_idle_no_effect) else $error("idle flag reaches irq");

   property p_empty_no_effect;
      @(posedge core_clk) disable iff (rst)
      (!ctrl2_r[ubi_pkg::CTL_TXE_IE] && !(ctrl2_r[ubi_pkg::CTL_TXI_IE] && flg_r.tx_idle)
       && !(ctrl2_r[ubi_pkg::CTL_RX_IE] && (flg_r.rx_avail || flg_r.overrun))) |-> !uart_irq;
   endproperty
   a_empty_no_effect: assert property (p_empty_no_effect) else $error("empty flag reaches irq");

   property p_irq_off;
      @(posedge core_clk) disable iff (rst)
      !uart_en |-> !uart_irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq while disabled");

   property p_tx_handoff;
      @(posedge core_clk) disable iff (rst)
      tx_accept |=> (tx_load && tx_byte == $past(bus.wdata));
   endproperty
   a_tx_handoff: assert property (p_tx_handoff) else $error("byte not handed over");

   property p_empty_cleared;
      @(posedge core_clk) disable iff (rst)
      (tx_accept && !tx_taken) |=> !flg_r.tx_empty;
   endproperty
   a_empty_cleared: assert property (p_empty_cleared) else $error("empty flag kept");

   property p_load_single;
      @(posedge core_clk) disable iff (rst)
      tx_load |=> !tx_load;
   endproperty
   a_load_single: assert property (p_load_single) else $error("load pulse too long");

   property p_rx_capture;
      @(posedge core_clk) disable iff (rst)
      (rx_valid && !off) |=> (rxbuf_r == $past(rx_byte) && flg_r.rx_avail);
   endproperty
   a_rx_capture: assert property (p_rx_capture) else $error("rx byte not held");

   property p_disable_ctrl;
      @(posedge core_clk) disable iff (rst)
      disabling |=> (ctrl2_r == ($past(ctrl2_r) & 8'h3F) && !ferr_r && !perr_r && !nf_r);
   endproperty
   a_disable_ctrl: assert property (p_disable_ctrl) else $error("disable control wrong");

   property p_rx_read_clears;
      @(posedge core_clk) disable iff (rst)
      (rd_data && !rx_valid) |=> !flg_r.rx_avail;
   endproperty
   a_rx_read_clears: assert property (p_rx_read_clears) else $error("rx flag not cleared");

   property p_rdata_idle;
      @(posedge core_clk) disable iff (rst)
      !bus.rd |=> (rdata == 8'h00);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
endmodule : ubi_uart_ctl
`default_nettype wire

/* File: shared/ubi_pkg.sv */
`default_nettype none
package ubi_pkg;
   // Register word addresses on the plain port
   localparam logic [2:0] ADDR_CTRL2 = 3'h0;
   localparam logic [2:0] ADDR_DATA = 3'h1;
   localparam logic [2:0] ADDR_DIV = 3'h2;
   localparam logic [2:0] ADDR_STATUS = 3'h3;
   localparam logic [2:0] ADDR_CTRL1 = 3'h4;
   localparam logic [2:0] ADDR_IRQ_STAT = 3'h5;
   localparam logic [2:0] ADDR_IRQ_MASK = 3'h6;
   // Control-two field positions
   localparam int CTL_TX_EN = 7;
   localparam int CTL_RX_EN = 6;
   localparam int CTL_HS_SEL = 5;
   localparam int CTL_RX_IE = 2;
   localparam int CTL_TXI_IE = 1;
   localparam int CTL_TXE_IE = 0;
   // Status field positions and the control-one enable position
   localparam int ST_OVERRUN = 5;
   localparam int ST_RX_AVAIL = 2;
   localparam int ST_TX_IDLE = 1;
   localparam int ST_TX_EMPTY = 0;
   localparam int CTL1_UART_EN = 7;
   // Event bits of the sticky interrupt status
   localparam int EV_RX = 0;
   localparam int EV_TX_IDLE = 1;
   localparam int EV_TX_EMPTY = 2;
   localparam int EV_WIDTH = 3;
   // Reset values
   localparam logic [7:0] CTRL2_RST = 8'h00;
   localparam logic [7:0] DIV_RST = 8'h00;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   // Prescale counts per timer step
   localparam int PRE_LOW = 64;
   localparam int PRE_HIGH = 16;
   localparam logic [5:0] PRE_LOW_LAST = 6'(PRE_LOW - 1);
   localparam logic [5:0] PRE_HIGH_LAST = 6'(PRE_HIGH - 1);

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ubi_bus_t;

   typedef struct packed {
      logic overrun;
      logic rx_avail;
      logic tx_idle;
      logic tx_empty;
   } ubi_flags_t;
endpackage : ubi_pkg
`default_nettype wire

/* File: design/ubi_baud_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module ubi_baud_gen (
   input wire logic core_clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic run, // Generator running
   input wire logic high_speed, // 1 divides by 16(N+1), 0 by 64(N+1)
   input wire logic [7:0] divisor, // N
   output logic tick // One pulse per bit time
);
   logic [5:0] pre_r;
   logic [7:0] tmr_r;
   wire logic [5:0] pre_last = high_speed ? ubi_pkg::PRE_HIGH_LAST : ubi_pkg::PRE_LOW_LAST;
   wire logic pre_wrap = (pre_r >= pre_last);
   wire logic tmr_wrap = (tmr_r >= divisor);

   // Free-running 8-bit timer stepped once per prescale period
   always_ff @(posedge core_clk)
   begin
      if (rst || !run)
      begin
         pre_r <= 6'h00;
         tmr_r <= 8'h00;
         tick <= 1'b0;
      end
      else
      begin
         pre_r <= pre_wrap ? 6'h00 : pre_r + 6'h01;
         if (pre_wrap)
            tmr_r <= tmr_wrap ? 8'h00 : tmr_r + 8'h01;
         tick <= pre_wrap && tmr_wrap;
      end
   end

   // Tick spacing check; armed at the first tick after the setting last changed
   logic [15:0] gap_r;
   logic [7:0] div_q_r;
   logic hs_q_r;
   logic armed_r;
   wire logic cfg_chg = (divisor != div_q_r) || (high_speed != hs_q_r);
   always_ff @(posedge core_clk)
   begin
      if (rst || !run || tick)
         gap_r <= 16'h0001;
      else
         gap_r <= gap_r + 16'h0001;
   end
   always_ff @(posedge core_clk)
   begin
      div_q_r <= divisor;
      hs_q_r <= high_speed;
      if (rst || !run || cfg_chg)
         armed_r <= 1'b0;
      else if (tick)
         armed_r <= 1'b1;
   end
   wire logic [15:0] pre_cnt = high_speed ? 16'(ubi_pkg::PRE_HIGH) : 16'(ubi_pkg::PRE_LOW);
   wire logic [15:0] period = pre_cnt * ({8'h00, divisor} + 16'h0001);

   property p_tick_period;
      @(posedge core_clk) disable iff (rst || !run)
      (tick && armed_r && !cfg_chg) |-> (gap_r == period);
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("tick period wrong");

   property p_tick_not_late;
      @(posedge core_clk) disable iff (rst || !run)
      (armed_r && !cfg_chg) |-> (gap_r <= period);
   endproperty
   a_tick_not_late: assert property (p_tick_not_late) else $error("tick missing");
endmodule : ubi_baud_gen
`default_nettype wire

/* File: design/ubi_irq.sv */
`timescale 1ns/1ns
`default_nettype none
module ubi_irq #(
   parameter int W = 3 // Number of events
) (
   input wire logic core_clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic [W-1:0] ev, // Event pulses
   input wire logic clr_we, // Write-one-to-clear strobe
   input wire logic mask_we, // Mask write strobe
   input wire logic [W-1:0] wdata, // Write data
   output logic [W-1:0] stat_r, // Sticky status
   output logic [W-1:0] mask_r, // Mask, 1 lets a bit through
   output logic irq // Level interrupt
);
   wire logic [W-1:0] clr = clr_we ? wdata : '0;
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         stat_r <= '0;
         mask_r <= '0;
      end
      else
      begin
         stat_r <= (stat_r & ~clr) | ev;
         if (mask_we)
            mask_r <= wdata;
      end
   end
   assign irq = |(stat_r & mask_r);

   property p_set_wins;
      @(posedge core_clk) disable iff (rst)
      (|ev) |=> ((stat_r & $past(ev)) == $past(ev));
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost");
endmodule : ubi_irq
`default_nettype wire

/* File: bench/ubi_far_end.sv */
`timescale 1ns/1ns
`default_nettype none
module ubi_far_end #(
   parameter int LAT = 8 // Taken rises LAT+1 cycles after the edge that samples load
) (
   input wire logic core_clk, // System clock
   input wire logic tx_load, // Byte handed over
   input wire logic rx_go, // Bench asks for one received byte
   input wire logic [7:0] rx_b, // Byte to deliver
   input wire logic [2:0] rx_e, // Error bits to deliver with it
   output logic tx_taken, // Shifter took the byte
   output logic tx_done, // Stop bit sent
   output logic [7:0] rx_byte, // Received byte
   output logic rx_valid, // Byte complete
   output logic [2:0] rx_err // Frame, parity, noise errors
);
   int cnt = -1;
   logic [7:0] last = 8'h00;
   initial
   begin
      tx_taken = 1'b0;
      tx_done = 1'b0;
      rx_valid = 1'b0;
      rx_byte = 8'hff;
      rx_err = 3'h0;
   end
   always @(posedge core_clk)
   begin
      if (tx_load)
         cnt <= 0;
      else if (cnt >= 0 && cnt < 4 * LAT)
         cnt <= cnt + 1;
      else
         cnt <= -1;
      tx_taken <= (cnt == LAT);
      tx_done <= (cnt == 4 * LAT);
      rx_valid <= rx_go;
      rx_err <= rx_go ? rx_e : 3'h0;
      if (rx_go)
         last <= rx_b;
      // Outside a valid cycle the byte lines carry the inverse of the last byte
      rx_byte <= rx_go ? rx_b : ~last;
   end
endmodule : ubi_far_end
`default_nettype wire

/* File: bench/tb_uart_baud_and_irq_enables.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_uart_baud_and_irq_enables;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rx_go = 1'b0;
   logic [7:0] rx_b = 8'h00;
   logic [2:0] rx_e = 3'h0;
   logic [7:0] rdata, tx_byte, rx_byte, v;
   logic uart_irq, sys_irq, baud_tick, tx_load, tx_taken, tx_done, rx_valid;
   logic tx_enable, rx_enable;
   logic [2:0] rx_err;
   int n_mismatch = 0;
   int n_tests = 0;

   always #5 core_clk = ~core_clk;

   ubi_uart_ctl dut (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .uart_irq(uart_irq), .sys_irq(sys_irq), .baud_tick(baud_tick),
      .tx_byte(tx_byte), .tx_load(tx_load), .tx_taken(tx_taken), .tx_done(tx_done),
      .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_frame_err(rx_err[2]),
      .rx_parity_err(rx_err[1]), .rx_noise(rx_err[0]), .tx_enable(tx_enable),
      .rx_enable(rx_enable));

   ubi_far_end #(.LAT(8)) far (.core_clk(core_clk), .tx_load(tx_load), .rx_go(rx_go),
      .rx_b(rx_b), .rx_e(rx_e), .tx_taken(tx_taken), .tx_done(tx_done), .rx_byte(rx_byte),
      .rx_valid(rx_valid), .rx_err(rx_err));

   task automatic stop_test;
      if (n_mismatch == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic bw(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
      #1;
   endtask : bw

   task automatic br(input logic [2:0] a);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask : br

   task automatic rc(input logic [2:0] a, input logic [7:0] e);
      br(a);
      chk(v, e);
   endtask : rc

   task automatic rx(input logic [7:0] b, input logic [2:0] e);
      @(posedge core_clk);
      rx_b <= b;
      rx_e <= e;
      rx_go <= 1'b1;
      @(posedge core_clk);
      rx_go <= 1'b0;
      rx_e <= 3'h0;
      repeat (3) @(posedge core_clk);
      #1;
   endtask : rx

   task automatic tick_wait(output int c);
      c = 0;
      do
      begin
         @(posedge core_clk);
         #1;
         c++;
      end while (baud_tick !== 1'b1 && c < 20000);
   endtask : tick_wait

   task automatic baud(input logic [7:0] n, input logic hs, input int e);
      int c;
      bw(ubi_pkg::ADDR_DIV, n);
      bw(ubi_pkg::ADDR_CTRL2, {2'b11, hs, 5'h00});
      tick_wait(c);
      tick_wait(c);
      tick_wait(c);
      chk(16'(c), 16'(e));
   endtask : baud

   task automatic t_reset;
      rc(ubi_pkg::ADDR_CTRL2, 8'h00);
      rc(ubi_pkg::ADDR_DIV, 8'h00);
      rc(ubi_pkg::ADDR_STATUS, 8'h03);
      rc(3'h7, 8'h00);
      chk(16'(uart_irq), 16'h0000);
      chk(16'(sys_irq), 16'h0000);
   endtask : t_reset

   task automatic t_ien;
      bw(ubi_pkg::ADDR_CTRL1, 8'h80);
      bw(ubi_pkg::ADDR_CTRL2, 8'hc1);
      chk(16'(uart_irq), 16'h0001);
      chk(16'({tx_enable, rx_enable}), 16'h0003);
      bw(ubi_pkg::ADDR_CTRL2, 8'hc0);
      chk(16'(uart_irq), 16'h0000);
      bw(ubi_pkg::ADDR_CTRL2, 8'hc2);
      chk(16'(uart_irq), 16'h0001);
      bw(ubi_pkg::ADDR_CTRL2, 8'hc4);
      chk(16'(uart_irq), 16'h0000);
      bw(ubi_pkg::ADDR_CTRL2, 8'hc7);
      chk(16'(uart_irq), 16'h0001);
   endtask : t_ien

   task automatic t_tx;
      bw(ubi_pkg::ADDR_CTRL2, 8'hc1);
      bw(ubi_pkg::ADDR_DATA, 8'h11);
      chk(16'(tx_load), 16'h0000);
      rc(ubi_pkg::ADDR_STATUS, 8'h03);
      bw(ubi_pkg::ADDR_DATA, 8'ha5);
      chk(16'(tx_load), 16'h0001);
      chk(16'(tx_byte), 16'h00a5);
      chk(16'(uart_irq), 16'h0000);
      br(ubi_pkg::ADDR_STATUS);
      chk(16'(v[0]), 16'h0000);
      bw(ubi_pkg::ADDR_DATA, 8'h5a);
      chk(16'(tx_load), 16'h0000);
      repeat (60) @(posedge core_clk);
      #1;
      chk(16'(uart_irq), 16'h0001);
      rc(ubi_pkg::ADDR_STATUS, 8'h03);
   endtask : t_tx

   task automatic t_rx;
      bw(ubi_pkg::ADDR_CTRL2, 8'hc0);
      rx(8'h3c, 3'h0);
      chk(16'(uart_irq), 16'h0000);
      bw(ubi_pkg::ADDR_CTRL2, 8'hc4);
      chk(16'(uart_irq), 16'h0001);
      rc(ubi_pkg::ADDR_STATUS, 8'h07);
      rc(ubi_pkg::ADDR_DATA, 8'h3c);
      chk(16'(uart_irq), 16'h0000);
      rx(8'h81, 3'h0);
      rx(8'h42, 3'h0);
      chk(16'(uart_irq), 16'h0001);
      rc(ubi_pkg::ADDR_STATUS, 8'h27);
      br(ubi_pkg::ADDR_DATA);
      chk(16'(uart_irq), 16'h0000);
   endtask : t_rx

   task automatic t_evt;
      rc(ubi_pkg::ADDR_IRQ_STAT, 8'h07);
      chk(16'(sys_irq), 16'h0000);
      bw(ubi_pkg::ADDR_IRQ_MASK, 8'h04);
      chk(16'(sys_irq), 16'h0001);
      bw(ubi_pkg::ADDR_IRQ_STAT, 8'h04);
      chk(16'(sys_irq), 16'h0000);
      rc(ubi_pkg::ADDR_IRQ_STAT, 8'h03);
      bw(ubi_pkg::ADDR_IRQ_MASK, 8'h03);
      chk(16'(sys_irq), 16'h0001);
      bw(ubi_pkg::ADDR_IRQ_STAT, 8'h03);
      chk(16'(sys_irq), 16'h0000);
   endtask : t_evt

   task automatic t_baud;
      baud(8'h02, 1'b1, 48);
      baud(8'h02, 1'b0, 192);
      baud(8'h00, 1'b1, 16);
      baud(8'h00, 1'b0, 64);
      baud(8'hff, 1'b1, 4096);
   endtask : t_baud

   task automatic t_off;
      bw(ubi_pkg::ADDR_CTRL2, 8'he5);
      bw(ubi_pkg::ADDR_DIV, 8'h2a);
      rx(8'h99, 3'h7);
      rc(ubi_pkg::ADDR_STATUS, 8'h1f);
      bw(ubi_pkg::ADDR_CTRL1, 8'h00);
      rc(ubi_pkg::ADDR_CTRL2, 8'h25);
      rc(ubi_pkg::ADDR_DIV, 8'h2a);
      rc(ubi_pkg::ADDR_STATUS, 8'h03);
      chk(16'({tx_enable, rx_enable, uart_irq}), 16'h0000);
   endtask : t_off

   initial
   begin
      #400_000;
      n_mismatch++;
      stop_test();
   end

   initial
   begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_ien();
      t_tx();
      t_rx();
      t_evt();
      t_baud();
      t_off();
      stop_test();
   end
endmodule : tb_uart_baud_and_irq_enables
`default_nettype wire
